// *** rtl/ocpa_pkg.sv ***
package ocpa_pkg;
  // register byte offsets
  localparam logic [7:0] OCPA_OFS_CTRL = 8'h00;
  localparam logic [7:0] OCPA_OFS_DIV_RATIO = 8'h04;
  localparam logic [7:0] OCPA_OFS_HIGH_WIDTH = 8'h08;
  localparam logic [7:0] OCPA_OFS_SHIFT = 8'h0c;
  localparam logic [7:0] OCPA_OFS_BUF_CFG = 8'h10;
  localparam logic [7:0] OCPA_OFS_STATUS = 8'h14;
  // control register fields
  localparam int OCPA_CTRL_RUN_BIT = 0;
  localparam logic [31:0] OCPA_CTRL_RST = 32'h0000_0000;
  // reset values of divider registers
  localparam logic [31:0] OCPA_DIV_RATIO_RST = 32'h0000_0008;
  localparam logic [31:0] OCPA_HIGH_WIDTH_RST = 32'h0000_0000;
  localparam logic [31:0] OCPA_SHIFT_RST = 32'h0000_0000;
  // status register fields
  localparam int OCPA_STAT_PEND_BIT = 0;
  localparam int OCPA_STAT_CLAMP_BIT = 1;
  localparam int OCPA_STAT_LEVEL_BIT = 2;
  localparam int OCPA_STAT_PULSE_BIT = 3;
  // per-buffer config slice, 16 bits per buffer
  localparam int OCPA_BUF_CFG_W = 16;
  localparam int OCPA_BUF_EN_POS = 0;
  localparam int OCPA_BUF_SE_POS = 1;
  localparam int OCPA_BUF_INV_POS = 2;
  localparam int OCPA_BUF_SWING_POS = 3;
  localparam int OCPA_BUF_XING_POS = 5;
  localparam int OCPA_BUF_SUPPLY_POS = 8;
  localparam logic [15:0] OCPA_BUF_CFG_RST = 16'h0000;
  // shortest half period when shortening, in source periods
  localparam int OCPA_MIN_HALF = 2;
  // period length arithmetic width: two 2^32 halves plus sign
  localparam int OCPA_LEN_W = 36;

  typedef enum logic [1:0] {
    OCPA_SWING_410MV,
    OCPA_SWING_600MV,
    OCPA_SWING_750MV,
    OCPA_SWING_900MV
  } ocpa_swing_e;

  typedef struct packed {
    logic [4:0] unused;
    logic [2:0] supply_level_select;
    logic [2:0] crossing_level_select;
    ocpa_swing_e swing_select;
    logic invert_complement;
    logic single_ended;
    logic enable;
  } ocpa_buf_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wstb;
    logic rstb;
  } ocpa_reg_req_s;
endpackage

// *** rtl/ocpa_output_stage.sv ***
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// What this block does
// [R1] shifts edges only in whole source periods
// [R2] each stage has its own adjuster
// [R3] shortening clamps halves at two periods each
// [R4] host avoids coarse shift for ratios 1-4
// [R5] one shift reaches 2^31 in total
// [R6] positive lengthens, negative shortens, one period
// [R7] symmetric duty splits shift over both halves
// [R8] pulse duty applies shift to low only
// [R9] successive shifts accepted without limit
// [R10] buffers drive differential or two single-ended
// [R11] single-ended pins match, complement optionally inverted
// [R12] two-bit swing code picks differential swing
// [R13] integer divider by 32-bit ratio
// [R14] zero high width means symmetric duty
// [R15] high width below ratio, pulses high-going
// [R16] shift consumed once at next period boundary
module ocpa_output_stage
  import ocpa_pkg::*;
#(
  parameter int NUM_BUF = 2
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire ocpa_reg_req_s i_reg_req,
  output logic [31:0] o_rdata,
  output logic [NUM_BUF-1:0] o_true_pin,
  output logic [NUM_BUF-1:0] o_complement_pin,
  output logic [NUM_BUF-1:0] o_single_ended,
  output logic [NUM_BUF*2-1:0] o_swing_select,
  output logic [NUM_BUF*3-1:0] o_crossing_level_select,
  output logic [NUM_BUF*3-1:0] o_supply_level_select
);
  typedef enum logic {OCPA_PH_HIGH, OCPA_PH_LOW} ocpa_phase_e;

  logic [31:0] ctrl_reg;
  logic [31:0] div_ratio_reg;
  logic [31:0] high_width_reg;
  logic [31:0] shift_reg;
  logic shift_pend_reg;
  logic clamp_reg;
  ocpa_buf_cfg_s buf_cfg_reg [NUM_BUF];
  logic [31:0] rdata_reg;
  ocpa_phase_e phase_reg;
  logic [OCPA_LEN_W-1:0] cnt_reg;
  logic [OCPA_LEN_W-1:0] low_len_reg;
  logic level_reg;
  logic [NUM_BUF-1:0] true_reg;
  logic [NUM_BUF-1:0] comp_reg;

  logic run;
  logic pulse_mode;
  logic period_start;
  logic phase_end;
  logic signed [OCPA_LEN_W-1:0] ratio_s;
  logic signed [OCPA_LEN_W-1:0] base_h;
  logic signed [OCPA_LEN_W-1:0] base_l;
  logic signed [OCPA_LEN_W-1:0] adj;
  logic signed [OCPA_LEN_W-1:0] adj_h;
  logic signed [OCPA_LEN_W-1:0] adj_l;
  logic signed [OCPA_LEN_W-1:0] sum_h;
  logic signed [OCPA_LEN_W-1:0] sum_l;
  logic signed [OCPA_LEN_W-1:0] lim;
  logic signed [OCPA_LEN_W-1:0] new_h;
  logic signed [OCPA_LEN_W-1:0] new_l;
  logic clamp_now;
  logic wr_shift;
  logic wr_ctrl;
  logic wr_ratio;
  logic wr_width;
  logic wr_buf_cfg;
  logic [31:0] status_word;
  logic [31:0] cfg_word;

  assign run = ctrl_reg[OCPA_CTRL_RUN_BIT];
  // a high width not below the ratio cannot be honoured, so fall back to symmetric
  assign pulse_mode = (high_width_reg != 32'h0000_0000) &&
                      (high_width_reg < div_ratio_reg); // [R14] [R15]
  assign phase_end = (cnt_reg <= {{(OCPA_LEN_W-1){1'b0}}, 1'b1});
  assign period_start = run && phase_end && (phase_reg == OCPA_PH_LOW);
  assign wr_shift = i_reg_req.wstb && (i_reg_req.addr == OCPA_OFS_SHIFT);
  // exact address decode; a write to an unmapped offset is dropped without notice
  assign wr_ctrl = i_reg_req.wstb && (i_reg_req.addr == OCPA_OFS_CTRL);
  assign wr_ratio = i_reg_req.wstb && (i_reg_req.addr == OCPA_OFS_DIV_RATIO);
  assign wr_width = i_reg_req.wstb && (i_reg_req.addr == OCPA_OFS_HIGH_WIDTH);
  assign wr_buf_cfg = i_reg_req.wstb && (i_reg_req.addr == OCPA_OFS_BUF_CFG);

  // period length planning, evaluated for the period about to start
  always_comb begin
    ratio_s = OCPA_LEN_W'({4'h0, div_ratio_reg}); // [R13]
    if (pulse_mode) begin
      base_h = OCPA_LEN_W'({4'h0, high_width_reg}); // [R14]
    end else begin
      base_h = ratio_s >>> 1; // [R14]
    end
    base_l = ratio_s - base_h;
  end

  // signed shift, split between the halves by duty mode
  always_comb begin
    if (shift_pend_reg) begin
      // whole source periods only, sign extended to keep both halves in range
      adj = OCPA_LEN_W'(signed'(shift_reg)); // [R1] [R2] [R5] [R6]
    end else begin
      adj = '0; // [R16]
    end
    if (pulse_mode) begin
      adj_h = '0; // [R8]
      adj_l = adj; // [R8]
    end else begin
      adj_h = adj >>> 1; // [R7]
      adj_l = adj - adj_h; // [R7]
    end
    sum_h = base_h + adj_h; // [R6]
    sum_l = base_l + adj_l; // [R6]
  end

  // each half is held at or above its smallest legal length
  always_comb begin
    // shortening floors at two per half; otherwise one is the least a counter can hold
    lim = adj[OCPA_LEN_W-1] ? OCPA_LEN_W'(OCPA_MIN_HALF) : OCPA_LEN_W'(1);
    clamp_now = 1'b0;
    new_h = sum_h;
    new_l = sum_l;
    if (sum_h < lim) begin
      new_h = lim; // [R3]
      clamp_now = adj[OCPA_LEN_W-1]; // [R3]
    end
    if (sum_l < lim) begin
      new_l = lim; // [R3]
      clamp_now = adj[OCPA_LEN_W-1]; // [R3]
    end
  end

  // control register; only the run bit acts, the rest reads back as written
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_reg <= OCPA_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_reg_req.wdata;
    end
  end

  // division ratio, taken up at the next period start
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      div_ratio_reg <= OCPA_DIV_RATIO_RST;
    end else if (wr_ratio) begin
      div_ratio_reg <= i_reg_req.wdata; // [R13]
    end
  end

  // high width; a width at or above the ratio is kept but ignored by pulse_mode
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      high_width_reg <= OCPA_HIGH_WIDTH_RST;
    end else if (wr_width) begin
      high_width_reg <= i_reg_req.wdata; // [R14]
    end
  end

  // coarse shift value
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shift_reg <= OCPA_SHIFT_RST;
    end else if (wr_shift) begin
      shift_reg <= i_reg_req.wdata; // [R9]
    end
  end

  // buffer configuration, one slice per buffer
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int b = 0; b < NUM_BUF; b++) begin
        buf_cfg_reg[b] <= ocpa_buf_cfg_s'(OCPA_BUF_CFG_RST);
      end
    end else if (wr_buf_cfg) begin
      for (int b = 0; b < NUM_BUF; b++) begin
        buf_cfg_reg[b] <= ocpa_buf_cfg_s'(i_reg_req.wdata[b*OCPA_BUF_CFG_W +: OCPA_BUF_CFG_W]);
      end
    end
  end

  // pending shift: a fresh write in the consuming cycle stays pending
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shift_pend_reg <= 1'b0;
    end else if (wr_shift) begin
      shift_pend_reg <= 1'b1; // [R9] [R16]
    end else if (period_start) begin
      shift_pend_reg <= 1'b0; // [R16]
    end
  end

  // clamp flag reports the outcome of the last consumed shift
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      clamp_reg <= 1'b0;
    end else if (period_start && shift_pend_reg) begin
      clamp_reg <= clamp_now; // [R3]
    end
  end

  // integer divider with coarse adjuster
  // the level flips only at phase ends or when stopped, so every edge sits on a whole source period
  always_ff @(posedge i_mclk) begin
    if (i_srst || !run) begin
      // parks low so the next enabled cycle begins a fresh period
      phase_reg <= OCPA_PH_LOW;
      cnt_reg <= OCPA_LEN_W'(1);
      low_len_reg <= OCPA_LEN_W'(1);
      level_reg <= 1'b0;
    end else if (phase_end) begin
      unique case (phase_reg)
        OCPA_PH_LOW: begin
          phase_reg <= OCPA_PH_HIGH;
          cnt_reg <= new_h; // [R6] [R16]
          low_len_reg <= new_l; // [R6]
          level_reg <= 1'b1; // [R15]
        end
        OCPA_PH_HIGH: begin
          phase_reg <= OCPA_PH_LOW;
          cnt_reg <= low_len_reg;
          level_reg <= 1'b0;
        end
      endcase
    end else begin
      cnt_reg <= cnt_reg - OCPA_LEN_W'(1); // [R1]
    end
  end

  // output buffers, each fed from this stage's divider only
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      true_reg <= '0;
      comp_reg <= '0;
    end else begin
      for (int b = 0; b < NUM_BUF; b++) begin
        if (!buf_cfg_reg[b].enable) begin
          true_reg[b] <= 1'b0;
          comp_reg[b] <= 1'b0;
        end else if (buf_cfg_reg[b].single_ended) begin
          true_reg[b] <= level_reg; // [R11]
          // in-phase copies couple more noise into neighbours, inverted is the quiet choice
          comp_reg[b] <= level_reg ^ buf_cfg_reg[b].invert_complement; // [R11]
        end else begin
          true_reg[b] <= level_reg; // [R10]
          comp_reg[b] <= ~level_reg; // [R10]
        end
      end
    end
  end

  // status word, gathered here so the read mux stays a plain select
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[OCPA_STAT_PEND_BIT] = shift_pend_reg;
    status_word[OCPA_STAT_CLAMP_BIT] = clamp_reg;
    status_word[OCPA_STAT_LEVEL_BIT] = level_reg;
    status_word[OCPA_STAT_PULSE_BIT] = pulse_mode;
  end

  // configuration read-back, one slice per buffer, unused slices read as zero
  always_comb begin
    cfg_word = 32'h0000_0000;
    for (int b = 0; b < NUM_BUF; b++) begin
      cfg_word[b*OCPA_BUF_CFG_W +: OCPA_BUF_CFG_W] = buf_cfg_reg[b];
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_reg_req.rstb) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      unique case (i_reg_req.addr)
        OCPA_OFS_CTRL: rdata_reg <= ctrl_reg;
        OCPA_OFS_DIV_RATIO: rdata_reg <= div_ratio_reg;
        OCPA_OFS_HIGH_WIDTH: rdata_reg <= high_width_reg;
        OCPA_OFS_SHIFT: rdata_reg <= shift_reg;
        OCPA_OFS_BUF_CFG: rdata_reg <= cfg_word;
        OCPA_OFS_STATUS: rdata_reg <= status_word;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  assign o_true_pin = true_reg;
  assign o_complement_pin = comp_reg;

  // pad settings come straight from the configuration flops
  always_comb begin
    for (int b = 0; b < NUM_BUF; b++) begin
      o_single_ended[b] = buf_cfg_reg[b].single_ended; // [R10]
      o_swing_select[b*2 +: 2] = buf_cfg_reg[b].swing_select; // [R12]
      o_crossing_level_select[b*3 +: 3] = buf_cfg_reg[b].crossing_level_select;
      o_supply_level_select[b*3 +: 3] = buf_cfg_reg[b].supply_level_select;
    end
  end
endmodule

// *** bench/ocpa_output_stage_sva.sv ***
`timescale 1ns/1ps
module ocpa_stage_chk
  import ocpa_pkg::*;
#(
  parameter int NUM_BUF = 2
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire ocpa_reg_req_s i_reg_req,
  input wire logic [31:0] o_rdata,
  input wire logic [NUM_BUF-1:0] o_true_pin,
  input wire logic [NUM_BUF-1:0] o_complement_pin,
  input wire logic [NUM_BUF-1:0] o_single_ended,
  input wire logic [NUM_BUF*2-1:0] o_swing_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic wr_cfg;
  assign wr_cfg = i_reg_req.wstb && i_reg_req.addr == OCPA_OFS_BUF_CFG;
  AST_RST_QUIET: assert property (disable iff (1'b0) i_srst |=> o_rdata == 32'h0
    && o_true_pin == '0) else $error("outputs not cleared by reset");
  AST_RD_IDLE: assert property (!i_reg_req.rstb |=> o_rdata == 32'h0)
    else $error("read data outside its slot");
  AST_UNMAPPED: assert property (i_reg_req.rstb && i_reg_req.addr == 8'hfc |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SWING_CFG: assert property (wr_cfg |=> o_swing_select[1:0] == $past(i_reg_req.wdata[4:3]))
    else $error("swing code not applied");
  AST_SE_CFG: assert property (wr_cfg |=> o_single_ended[0] == $past(i_reg_req.wdata[1]))
    else $error("buffer mode not applied");
  AST_DIFF_COMP: assert property ($stable(o_single_ended) && !o_single_ended[0]
    && o_true_pin[0] |-> !o_complement_pin[0]) else $error("differential pins not opposite");
  AST_SE_EDGE: assert property (o_single_ended[0] && $stable(o_single_ended)
    && $past(o_true_pin[0] | o_complement_pin[0]) && $changed(o_true_pin[0])
    |-> $changed(o_complement_pin[0])) else $error("single-ended pins out of phase");
  AST_DISABLED: assert property (wr_cfg && !i_reg_req.wdata[0] |=> ##1
    !o_true_pin[0] && !o_complement_pin[0]) else $error("disabled buffer still drives");
endmodule
bind ocpa_output_stage ocpa_stage_chk #(.NUM_BUF(NUM_BUF)) ocpa_stage_chk_inst (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_reg_req(i_reg_req), .o_rdata(o_rdata),
  .o_true_pin(o_true_pin), .o_complement_pin(o_complement_pin),
  .o_single_ended(o_single_ended), .o_swing_select(o_swing_select));

// *** bench/ocpa_rx_model.sv ***
`timescale 1ns/1ps
module ocpa_rx_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic [31:0] o_hi_len,
  output logic [31:0] o_lo_len,
  output logic [31:0] o_edges
);
  logic prev_reg;
  logic [31:0] run_reg;
  // listens only, so it never has to release a line
  always_ff @(posedge i_mclk) begin
    prev_reg <= i_srst ? 1'b0 : i_pin;
    run_reg <= (i_srst || i_pin != prev_reg) ? 32'h1 : run_reg + 32'h1;
    if (i_srst) begin
      o_edges <= 32'h0;
    end else if (i_pin != prev_reg) begin
      o_edges <= o_edges + 32'h1;
      if (i_pin)
        o_lo_len <= run_reg;
      else
        o_hi_len <= run_reg; // pulses measured as high-going
    end
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ocpa_pkg::*;
  logic i_mclk;
  logic i_srst;
  ocpa_reg_req_s req;
  logic [31:0] o_rdata, hi, lo, edges, d;
  logic [1:0] tp, cp, se;
  logic [3:0] sw;
  logic [5:0] xs, ss;
  int err_count, samples_checked, seed, n, hw, s, h, l, ah, al;

  ocpa_output_stage #(.NUM_BUF(2)) ocpa_output_stage_inst (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_reg_req(req), .o_rdata(o_rdata), .o_true_pin(tp), .o_complement_pin(cp),
    .o_single_ended(se), .o_swing_select(sw), .o_crossing_level_select(xs),
    .o_supply_level_select(ss));
  ocpa_rx_model ocpa_rx_model_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_pin(tp[0]),
    .o_hi_len(hi), .o_lo_len(lo), .o_edges(edges));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: v, wstb: 1'b1, rstb: 1'b0};
    @(posedge i_mclk);
    req.wstb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: 32'h0, wstb: 1'b0, rstb: 1'b1};
    @(posedge i_mclk);
    req.rstb <= 1'b0;
    #1 v = o_rdata;
  endtask
  // bounded wait for the receiver to see the next pin transition
  task automatic next_edge();
    logic [31:0] e0;
    e0 = edges;
    for (int i = 0; i < 3000 && edges === e0; i++) begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  function automatic int half(int b, int a, int sh);
    if (b + a < 2 && sh < 0)
      return 2;
    if (b + a < 1)
      return 1;
    return b + a;
  endfunction

  initial begin
    repeat (40000) @(posedge i_mclk);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    seed = 81044;
    err_count = 0;
    samples_checked = 0;
    req = '0;
    i_srst = 1'b1;
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(i == 6 ? 8'hfc : 8'(i * 4), d);
      chk(d, i == 1 ? OCPA_DIV_RATIO_RST : 32'h0);
    end
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      wr(OCPA_OFS_BUF_CFG, {5'h0, 3'(7 - k), 3'(k), 2'(3 - k), 3'h1,
                            5'h0, 3'(k), 3'(7 - k), 2'(k), 3'h1});
      @(posedge i_mclk);
      #1 chk({16'h0, xs, ss, sw}, {16'h0, 3'(k), 3'(7 - k), 3'(7 - k), 3'(k), 2'(3 - k), 2'(k)});
    end
    // buffer mode is only changed while stopped so both pins switch together
    for (int m = 3; m >= 0; m--) begin
      wr(OCPA_OFS_CTRL, 32'h0);
      wr(OCPA_OFS_BUF_CFG, {16'h0001, m == 3 ? 16'h0 : 16'(1 + 2 * (m > 0) + 4 * (m == 2))});
      wr(OCPA_OFS_CTRL, 32'h1);
      repeat (20) begin
        @(posedge i_mclk);
        #1 chk({30'h0, tp[0], cp[0]}, {30'h0, m == 3 ? 2'b00 : {tp[0], tp[0] ^ (m != 1)}});
      end
    end
    $display("test buffer modes done");
    for (int it = 0; it < 8; it++) begin // successive shifts
      // low half of at least five lets the shift land before the next period start
      n = 9 + ($unsigned($random(seed)) % 15); // ratio kept above 4
      hw = it % 2 ? 2 + ($unsigned($random(seed)) % (n - 6)) : 0; // width below ratio
      s = it == 0 ? -1000 : it == 1 ? 41 : $random(seed) % (2 * n);
      h = hw > 0 ? hw : n / 2;
      l = n - h;
      ah = hw > 0 ? 0 : s >>> 1;
      al = s - ah;
      wr(OCPA_OFS_DIV_RATIO, n);
      wr(OCPA_OFS_HIGH_WIDTH, hw);
      repeat (5) next_edge();
      if (tp[0])
        next_edge();
      chk(hi, h);
      wr(OCPA_OFS_SHIFT, s);
      next_edge();
      chk(lo, l);
      next_edge();
      chk(hi, half(h, ah, s));
      next_edge();
      chk(lo, half(l, al, s));
      next_edge();
      chk(hi, h);
      next_edge();
      chk(lo, l);
      rd(OCPA_OFS_STATUS, d);
      chk({31'h0, d[1]}, {31'h0, s < 0 && (h + ah < 2 || l + al < 2)});
    end
    $display("test coarse shifts done");
    give_verdict();
  end
endmodule
